/* hdl/abt_pkg.sv */
// shared constants and types for the bus arbitration/transfer master
package abt_pkg;
   // widths
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int LEVELS = 4;
   // command codes on the user port
   localparam logic [2:0] CMD_READ = 3'h0;
   localparam logic [2:0] CMD_READ_PAUSE = 3'h1;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_WRITE_BYTE = 3'h3;
   localparam logic [2:0] CMD_RMW = 3'h4;
   localparam logic [2:0] CMD_RMW_BYTE = 3'h5;
   localparam logic [2:0] CMD_VECTOR = 3'h6;
   // transfer direction codes driven on the control lines
   localparam logic [1:0] CTL_IN = 2'h0;
   localparam logic [1:0] CTL_IN_PAUSE = 2'h1;
   localparam logic [1:0] CTL_OUT = 2'h2;
   localparam logic [1:0] CTL_OUT_BYTE = 2'h3;
   // level select: 0 is the non-processor level, 1..4 the lower levels
   localparam logic [2:0] LVL_NONPROC = 3'h0;
   localparam logic [2:0] LVL_MAX = 3'h4;
   // timing
   localparam int CLK_MHZ = 200;
   localparam int ADDR_SETUP_NS = 150;
   localparam int DESKEW_NS = 75;
   localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int DESKEW_CYC = (DESKEW_NS * CLK_MHZ + 999) / 1000;
   localparam int TIMER_W = 8;
   // reset values
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_REQUEST,
      ST_SELECTED,
      ST_SETUP,
      ST_SYNC,
      ST_DESKEW,
      ST_RELEASE_SYNC,
      ST_MODIFY,
      ST_DROP_BUS
   } abt_state_e;
endpackage : abt_pkg

/* hdl/abt_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module abt_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // data
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stage1 <= '0;
         dout <= '0;
      end
      else
      begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule : abt_sync

/* hdl/abt_fifo.sv */
// read-data fifo with registered head word
`timescale 1ns/1ps
module abt_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] rdPtr;
   logic [PW-1:0] wrPtr;
   logic [CW-1:0] count;
   logic push;
   logic pop;
   logic loadHead;
   logic fromMem;
   logic bypass;
   logic toMem;
   logic [CW-1:0] next_count;

   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign loadHead = !outValid || pop;
   assign fromMem = loadHead && (count != '0);
   // empty store and free head: word skips the array
   assign bypass = loadHead && (count == '0) && push;
   assign toMem = push && !bypass;

   always_comb
   begin
      next_count = count;
      if (toMem && !fromMem)
         next_count = count + CW'(1);
      else if (fromMem && !toMem)
         next_count = count - CW'(1);
   end

   always_ff @(posedge sys_clk)
   begin
      if (toMem)
         mem[wrPtr] <= inData;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdPtr <= '0;
         wrPtr <= '0;
         count <= '0;
      end
      else
      begin
         if (toMem)
            wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + PW'(1);
         if (fromMem)
            rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + PW'(1);
         count <= next_count;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         outValid <= 1'b0;
         outData <= '0;
      end
      else if (loadHead)
      begin
         outValid <= fromMem || bypass;
         if (fromMem)
            outData <= mem[rdPtr];
         else if (bypass)
            outData <= inData;
      end
   end

   // head counts toward depth so full is honest
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         inReady <= 1'b0;
      else
         inReady <= (32'(next_count) + ((outValid && !pop) || fromMem
            || bypass ? 32'd1 : 32'd0)) < 32'(DEPTH);
   end
endmodule : abt_fifo

/* hdl/abt_bus_master.sv */
// bus master: requests mastership, passes grants, runs one transfer (a read then a write for read-modify-write)
`timescale 1ns/1ps
module abt_bus_master
   import abt_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // user command port
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic [2:0] cmdOp,
   input wire logic [2:0] cmdLevel,
   input wire logic [ADDR_W-1:0] cmdAddr,
   input wire logic [DATA_W-1:0] cmdData,
   output logic cmdDone,
   output logic cmdError,
   // user read-data port
   output logic rspValid,
   input wire logic rspReady,
   output logic [DATA_W-1:0] rspData,
   // arbitration pins
   output logic nonproc_request,
   input wire logic nonproc_grant,
   output logic nonprocGrantPass,
   output logic [LEVELS-1:0] level_request_n,
   input wire logic [LEVELS-1:0] level_grant_n,
   output logic [LEVELS-1:0] levelGrantPass,
   output logic selection_ack,
   input wire logic busBusyIn,
   output logic busBusyOut,
   output logic busBusyOe_n,
   // transfer pins
   output logic [ADDR_W-1:0] busAddr,
   output logic busAddrOe_n,
   output logic [1:0] busCtl,
   input wire logic [DATA_W-1:0] busDataIn,
   output logic [DATA_W-1:0] busDataOut,
   output logic busDataOe_n,
   output logic master_sync,
   output logic interrupt_strobe,
   input wire logic slave_sync,
   // initialisation
   input wire logic busInit
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [LEVELS+3:0] pinsRaw;
   logic [LEVELS+3:0] pinsSync;
   logic [DATA_W-1:0] dataSync;
   logic grantNpSync;
   logic [LEVELS-1:0] grantLvSync;
   logic busyNow;
   logic ssynNow;
   logic initNow;

   assign pinsRaw = {busInit, slave_sync, busBusyIn, nonproc_grant,
      level_grant_n};
   assign grantLvSync = pinsSync[LEVELS-1:0];
   assign grantNpSync = pinsSync[LEVELS];
   assign busyNow = pinsSync[LEVELS+1];
   assign ssynNow = pinsSync[LEVELS+2];
   assign initNow = pinsSync[LEVELS+3];

   abt_sync #(.WIDTH(LEVELS + 4)) u_pin_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .din(pinsRaw),
      .dout(pinsSync)
   );

   // data lines only sampled after slave_sync plus deskew, still synced
   abt_sync #(.WIDTH(DATA_W)) u_data_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .din(busDataIn),
      .dout(dataSync)
   );

   ////////////////////////////////////////////////////////////////////////
   // response fifo
   logic fifoPush;
   logic fifoReady;
   logic [DATA_W-1:0] fifoData;

   abt_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rsp_fifo (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .inValid(fifoPush),
      .inReady(fifoReady),
      .inData(fifoData),
      .outValid(rspValid),
      .outReady(rspReady),
      .outData(rspData)
   );

   ////////////////////////////////////////////////////////////////////////
   // command latch
   abt_state_e state;
   logic [TIMER_W-1:0] timer;
   logic [2:0] op;
   logic [2:0] lvl;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdWord;
   logic writePhase;
   logic cmdTake;
   logic badCmd;
   logic grantSeen;
   logic isRead;
   logic isRmw;

   assign cmdTake = cmdValid && cmdReady;
   // vectors may not ride the non-processor level
   assign badCmd = (cmdLevel > LVL_MAX) || (cmdOp > CMD_VECTOR)
      || (cmdOp == CMD_VECTOR && cmdLevel == LVL_NONPROC);
   assign grantSeen = (lvl == LVL_NONPROC) ? grantNpSync
      : grantLvSync[lvl[1:0] - 2'h1];
   assign isRmw = (op == CMD_RMW) || (op == CMD_RMW_BYTE);
   assign isRead = (op == CMD_READ) || (op == CMD_READ_PAUSE)
      || (isRmw && !writePhase);
   // read words leave via the fifo during the deskew end of a read
   assign fifoPush = (state == ST_DESKEW) && isRead
      && (timer == '0) && !initNow;
   assign fifoData = dataSync;

   // ready only with fifo room, so a read never has nowhere to go
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         cmdReady <= 1'b0;
      else
         cmdReady <= (state == ST_IDLE) && !cmdTake && fifoReady
            && !initNow;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         op <= CMD_READ;
         lvl <= LVL_NONPROC;
         busAddr <= ADDR_RST;
         wdata <= DATA_RST;
      end
      else if (cmdTake)
      begin
         op <= cmdOp;
         lvl <= cmdLevel;
         busAddr <= cmdAddr;
         wdata <= cmdData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transfer sequencer
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= ST_IDLE;
         timer <= '0;
         writePhase <= 1'b0;
         rdWord <= DATA_RST;
         cmdDone <= 1'b0;
         cmdError <= 1'b0;
      end
      else
      begin
         cmdDone <= 1'b0;
         cmdError <= 1'b0;
         if (timer != '0)
            timer <= timer - TIMER_W'(1);
         if (initNow)
         begin
            state <= ST_IDLE;
            writePhase <= 1'b0;
            timer <= '0;
         end
         else
         begin
            case (state)
               ST_IDLE:
                  if (cmdTake)
                  begin
                     writePhase <= 1'b0;
                     if (badCmd)
                        cmdError <= 1'b1;
                     else
                        state <= ST_REQUEST;
                  end
               ST_REQUEST:
                  if (grantSeen)
                     state <= ST_SELECTED;
               // grant designates only; wait for the old master to leave
               ST_SELECTED:
                  if (!busyNow && !ssynNow && !grantSeen)
                  begin
                     state <= ST_SETUP;
                     timer <= TIMER_W'(ADDR_SETUP_CYC);
                  end
               ST_SETUP:
                  if (timer == '0)
                     state <= ST_SYNC;
               ST_SYNC:
                  if (ssynNow)
                  begin
                     state <= ST_DESKEW;
                     timer <= TIMER_W'(DESKEW_CYC);
                  end
               ST_DESKEW:
                  if (timer == '0)
                  begin
                     if (isRead)
                        rdWord <= dataSync;
                     state <= ST_RELEASE_SYNC;
                  end
               // strobe dropped; slave must answer by dropping its own
               ST_RELEASE_SYNC:
                  if (!ssynNow)
                     state <= (isRmw && !writePhase) ? ST_MODIFY
                        : ST_DROP_BUS;
               ST_MODIFY:
               begin
                  writePhase <= 1'b1;
                  state <= ST_SETUP;
                  timer <= TIMER_W'(ADDR_SETUP_CYC);
               end
               ST_DROP_BUS:
               begin
                  state <= ST_IDLE;
                  cmdDone <= 1'b1;
               end
               default:
                  state <= ST_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // arbitration pins
   logic reqOn;
   logic holdGrant;

   assign reqOn = (state == ST_REQUEST);
   // claimed grant blocked until the arbiter drops it
   assign holdGrant = (state == ST_REQUEST) || (state == ST_SELECTED);

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         nonproc_request <= 1'b0;
         level_request_n <= '0;
         nonprocGrantPass <= 1'b0;
         levelGrantPass <= '0;
         selection_ack <= 1'b0;
      end
      else
      begin
         nonproc_request <= reqOn && (lvl == LVL_NONPROC) && !initNow;
         for (int i = 0; i < LEVELS; i++)
         begin
            level_request_n[i] <= reqOn && !initNow
               && (lvl == 3'(i + 1));
            levelGrantPass[i] <= grantLvSync[i]
               && !(holdGrant && lvl == 3'(i + 1));
         end
         nonprocGrantPass <= grantNpSync
            && !(holdGrant && lvl == LVL_NONPROC);
         selection_ack <= (state == ST_SELECTED || (reqOn && grantSeen))
            && !initNow;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transfer pins
   logic ownBus;
   logic driveData;
   logic isVector;
   logic byteOut;

   assign ownBus = (state == ST_SETUP) || (state == ST_SYNC)
      || (state == ST_DESKEW) || (state == ST_RELEASE_SYNC)
      || (state == ST_MODIFY);
   assign isVector = (op == CMD_VECTOR);
   assign byteOut = (op == CMD_WRITE_BYTE) || (op == CMD_RMW_BYTE);
   assign driveData = ownBus && !isRead;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busBusyOut <= 1'b0;
         busBusyOe_n <= 1'b1;
         busAddrOe_n <= 1'b1;
         busCtl <= CTL_IN;
         busDataOut <= DATA_RST;
         busDataOe_n <= 1'b1;
         master_sync <= 1'b0;
         interrupt_strobe <= 1'b0;
      end
      else
      begin
         busBusyOut <= ownBus && !initNow;
         busBusyOe_n <= !(ownBus && !initNow);
         busAddrOe_n <= !(ownBus && !isVector && !initNow);
         busDataOe_n <= !(driveData && !initNow);
         if (isVector)
            busCtl <= CTL_IN;
         else if (isRmw && writePhase)
            busCtl <= byteOut ? CTL_OUT_BYTE : CTL_OUT;
         else if (isRmw || op == CMD_READ_PAUSE)
            busCtl <= CTL_IN_PAUSE;
         else if (op == CMD_READ)
            busCtl <= CTL_IN;
         else
            busCtl <= byteOut ? CTL_OUT_BYTE : CTL_OUT;
         // rmw writes back read word xored with the user mask
         busDataOut <= (isRmw && writePhase) ? (rdWord ^ wdata) : wdata;
         master_sync <= (state == ST_SYNC || state == ST_DESKEW)
            && !isVector && !initNow;
         interrupt_strobe <= (state == ST_SYNC || state == ST_DESKEW)
            && isVector && !initNow;
      end
   end
endmodule : abt_bus_master

/* dv/abt_bus_master_chk.sv */
// port-level assertions for the bus master
`timescale 1ns/1ps
module abt_bus_master_chk
   import abt_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // command port
   input wire logic cmdValid,
   input wire logic cmdReady,
   input wire logic [2:0] cmdOp,
   input wire logic [2:0] cmdLevel,
   input wire logic cmdDone,
   input wire logic cmdError,
   // arbitration
   input wire logic nonproc_request,
   input wire logic nonproc_grant,
   input wire logic nonprocGrantPass,
   input wire logic selection_ack,
   input wire logic busBusyOut,
   input wire logic busBusyOe_n,
   // transfer
   input wire logic [ADDR_W-1:0] busAddr,
   input wire logic busAddrOe_n,
   input wire logic busDataOe_n,
   input wire logic master_sync,
   input wire logic slave_sync,
   input wire logic busInit
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   logic take;
   assign take = cmdValid && cmdReady;

   vec_refused_a: assert property (
      take && cmdOp == CMD_VECTOR && cmdLevel == LVL_NONPROC |=> cmdError)
      else $error("vector on non-processor level not refused");
   level_refused_a: assert property (
      take && cmdLevel > LVL_MAX |=> cmdError && !nonproc_request)
      else $error("out of range level not refused");
   sync_ack_a: assert property (
      $fell(master_sync) && !$past(busInit, 3) |-> $past(slave_sync, 2))
      else $error("master_sync dropped without slave_sync");
   busy_held_a: assert property (
      $rose(master_sync) |-> !busBusyOe_n && busBusyOut && !busAddrOe_n)
      else $error("master_sync raised without holding the bus");
   addr_setup_a: assert property (
      $rose(master_sync) |-> $stable(busAddr) && !$past(busAddrOe_n, 28))
      else $error("address not set up before master_sync");
   grant_pass_a: assert property (
      (nonproc_grant && !nonproc_request && !selection_ack) [*5]
      |-> nonprocGrantPass)
      else $error("unclaimed grant not passed on");
   init_halt_a: assert property (
      busInit [*5] |-> busAddrOe_n && busDataOe_n && busBusyOe_n
      && !master_sync)
      else $error("bus not released under init");
   release_a: assert property (
      cmdDone |=> busBusyOe_n && busAddrOe_n && busDataOe_n)
      else $error("bus still held after done");
endmodule : abt_bus_master_chk

bind abt_bus_master abt_bus_master_chk chk (.*);

/* dv/abt_dev_model.sv */
// device model: arbiter, interrupt processor and word slave
`timescale 1ns/1ps
module abt_dev_model
   import abt_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // arbitration
   input wire logic nonproc_request,
   input wire logic [LEVELS-1:0] level_request_n,
   input wire logic selection_ack,
   input wire logic [LEVELS:0] otherReq,
   input wire logic [2:0] cpuLevel,
   output logic nonproc_grant = 1'h0,
   output logic [LEVELS-1:0] level_grant_n = 4'h0,
   // transfer
   input wire logic [ADDR_W-1:0] busAddr,
   input wire logic [1:0] busCtl,
   input wire logic [DATA_W-1:0] busDataOut,
   input wire logic master_sync,
   input wire logic interrupt_strobe,
   input wire logic slowSlave,
   output logic slave_sync = 1'h0,
   output logic [DATA_W-1:0] busDataIn = 16'h0000,
   output logic [DATA_W-1:0] lastVector = 16'h0000
);
   logic [DATA_W-1:0] mem [16] = '{default: 16'h0000};
   logic [LEVELS:0] req;
   logic [LEVELS:0] pick;
   int waitCnt = 0;
   int k;
   assign req = {level_request_n, nonproc_request} | otherReq;
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk)
   begin
      pick = 5'h00;
      if ({level_grant_n, nonproc_grant} != 5'h00)
      begin
         if (selection_ack || ({level_grant_n, nonproc_grant} & req) == 5'h00)
            {level_grant_n, nonproc_grant} <= 5'h00;
      end
      else if (!selection_ack)
      begin
         pick[0] = req[0];
         for (k = LEVELS; k >= 1; k--)
            if (req[k] && k > cpuLevel && pick == 5'h00)
               pick[k] = 1'h1;
         {level_grant_n, nonproc_grant} <= pick;
      end
   end
   // released data lines keep changing so a stale word is never sampled
   always @(posedge sys_clk)
   begin
      if (!(master_sync || interrupt_strobe))
      begin
         slave_sync <= 1'h0;
         waitCnt <= slowSlave ? 40 : 3;
         busDataIn <= ~busDataIn;
      end
      else if (waitCnt > 0)
      begin
         waitCnt <= waitCnt - 1;
         busDataIn <= ~busDataIn;
      end
      else if (!slave_sync)
      begin
         slave_sync <= 1'h1;
         if (interrupt_strobe)
            lastVector <= busDataOut;
         else if (!busCtl[1])
            busDataIn <= mem[busAddr[4:1]];
         else if (busCtl == CTL_OUT)
            mem[busAddr[4:1]] <= busDataOut;
         else if (busAddr[0])
            mem[busAddr[4:1]][15:8] <= busDataOut[15:8];
         else
            mem[busAddr[4:1]][7:0] <= busDataOut[7:0];
      end
   end
endmodule : abt_dev_model

/* dv/tb_abt_bus_master.sv */
// bench: command table through the bus master into the device model
`timescale 1ns/1ps
module tb_abt_bus_master
   import abt_pkg::*;
;
   typedef struct {
      logic [2:0] op;
      logic [2:0] lvl;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [1:0] chk;
      logic [DATA_W-1:0] exp;
      logic slow;
   } abt_row_s;
   logic sys_clk = 1'h0, nrst = 1'h0, cmdValid = 1'h0, rspReady = 1'h0;
   logic busInit = 1'h0, slowSlave = 1'h0, ended, err;
   logic [2:0] cmdOp = 3'h0, cmdLevel = 3'h0, cpuLevel = 3'h0;
   logic [ADDR_W-1:0] cmdAddr = 18'h00000, busAddr;
   logic [DATA_W-1:0] cmdData = 16'h0000, rspData, busDataIn, busDataOut;
   logic [DATA_W-1:0] lastVector;
   logic [LEVELS:0] otherReq = 5'h00;
   logic cmdReady, cmdDone, cmdError, rspValid, nonproc_request;
   logic nonproc_grant, nonprocGrantPass, selection_ack, busBusyIn;
   logic busBusyOut, busBusyOe_n, busAddrOe_n, busDataOe_n, master_sync;
   logic interrupt_strobe, slave_sync;
   logic [LEVELS-1:0] level_request_n, level_grant_n, levelGrantPass;
   logic [1:0] busCtl;
   int failures = 0, n_compared = 0, i, j;
   abt_row_s cmd;
   abt_row_s rows [14] = '{
      '{CMD_WRITE, 3'h1, 18'h00004, 16'h1234, 2'h0, 16'h0000, 1'h0},
      '{CMD_READ, 3'h0, 18'h00004, 16'h0000, 2'h1, 16'h1234, 1'h1},
      '{CMD_WRITE_BYTE, 3'h2, 18'h00005, 16'hab00, 2'h0, 16'h0000, 1'h0},
      '{CMD_READ_PAUSE, 3'h3, 18'h00004, 16'h0000, 2'h1, 16'hab34, 1'h0},
      '{CMD_RMW, 3'h4, 18'h00004, 16'h00ff, 2'h1, 16'hab34, 1'h1},
      '{CMD_READ, 3'h0, 18'h00004, 16'h0000, 2'h1, 16'habcb, 1'h0},
      '{CMD_RMW_BYTE, 3'h1, 18'h00006, 16'h000f, 2'h1, 16'h0000, 1'h0},
      '{CMD_READ, 3'h1, 18'h00006, 16'h0000, 2'h1, 16'h000f, 1'h0},
      '{CMD_WRITE_BYTE, 3'h4, 18'h00008, 16'h0055, 2'h0, 16'h0000, 1'h0},
      '{CMD_READ, 3'h2, 18'h00008, 16'h0000, 2'h1, 16'h0055, 1'h0},
      '{CMD_VECTOR, 3'h2, 18'h00000, 16'h0104, 2'h2, 16'h0000, 1'h0},
      '{CMD_VECTOR, 3'h0, 18'h00000, 16'h0104, 2'h3, 16'h0000, 1'h0},
      '{CMD_READ, 3'h5, 18'h00004, 16'h0000, 2'h3, 16'h0000, 1'h0},
      '{3'h7, 3'h1, 18'h00004, 16'h0000, 2'h3, 16'h0000, 1'h0}
   };
   // single master on the segment, so the busy wire is ours alone
   assign busBusyIn = !busBusyOe_n && busBusyOut;
   abt_bus_master #(.FIFO_DEPTH(8)) dut (.*);
   abt_dev_model model (.*);
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [DATA_W-1:0] seen,
                        input logic [DATA_W-1:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task automatic stall();
      failures++;
      $display("[ERR] %0t wait bound used up", $time);
      summarize();
   endtask : stall
   // pulses last one cycle, so one look per falling edge sees them
   task automatic wait_end(input int n, input logic must);
      ended = 1'h0;
      err = 1'h0;
      for (i = 0; i < n && !ended; i++)
      begin
         ended = cmdDone === 1'h1 || cmdError === 1'h1;
         err = cmdError === 1'h1;
         if (!ended)
            @(negedge sys_clk);
      end
      if (must && !ended)
         stall();
   endtask : wait_end
   task automatic run(input abt_row_s r, input int n, input logic must);
      @(negedge sys_clk);
      cmdOp = r.op;
      cmdLevel = r.lvl;
      cmdAddr = r.addr;
      cmdData = r.data;
      cmdValid = 1'h1;
      for (i = 0; i < 100 && cmdReady !== 1'h1; i++)
         @(negedge sys_clk);
      if (i == 100)
         stall();
      @(negedge sys_clk);
      cmdValid = 1'h0;
      wait_end(n, must);
   endtask : run
   task automatic pop(input logic [DATA_W-1:0] exp);
      for (i = 0; i < 20 && rspValid !== 1'h1; i++)
         @(negedge sys_clk);
      if (i == 20)
         stall();
      check(rspData, exp);
      rspReady = 1'h1;
      @(negedge sys_clk);
      rspReady = 1'h0;
   endtask : pop
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial
   begin
      repeat (4) @(negedge sys_clk);
      check(cmdReady, 1'h0);
      check(busAddrOe_n & busDataOe_n & busBusyOe_n, 1'h1);
      nrst = 1'h1;
      foreach (rows[j])
      begin
         slowSlave = rows[j].slow;
         run(rows[j], 2000, 1'h1);
         check(err, rows[j].chk == 2'h3);
         if (rows[j].chk == 2'h1)
            pop(rows[j].exp);
         if (rows[j].chk == 2'h2)
            check(lastVector, rows[j].data);
      end
      cmd = '{CMD_READ, 3'h2, 18'h00004, 16'h0000, 2'h1, 16'habcb, 1'h0};
      for (j = 0; j < 8; j++)
         run(cmd, 2000, 1'h1);
      repeat (3) @(negedge sys_clk);
      check(cmdReady, 1'h0);
      for (j = 0; j < 8; j++)
         pop(cmd.exp);
      @(negedge sys_clk);
      check(rspValid, 1'h0);
      cpuLevel = 3'h3;
      cmd = '{CMD_WRITE, 3'h3, 18'h0000a, 16'h5a5a, 2'h0, 16'h0000, 1'h0};
      run(cmd, 300, 1'h0);
      check(ended, 1'h0);
      check(level_grant_n, 4'h0);
      cpuLevel = 3'h2;
      wait_end(2000, 1'h1);
      cmd = '{CMD_READ, 3'h4, 18'h0000a, 16'h0000, 2'h1, 16'h5a5a, 1'h0};
      run(cmd, 2000, 1'h1);
      pop(cmd.exp);
      cpuLevel = 3'h0;
      otherReq = 5'h01;
      repeat (8) @(negedge sys_clk);
      check(nonprocGrantPass, 1'h1);
      otherReq = 5'h04;
      repeat (8) @(negedge sys_clk);
      check(levelGrantPass, 4'h2);
      otherReq = 5'h00;
      slowSlave = 1'h1;
      cmd = '{CMD_WRITE, 3'h1, 18'h00004, 16'h0bad, 2'h0, 16'h0000, 1'h0};
      run(cmd, 0, 1'h0);
      for (j = 0; j < 200 && master_sync !== 1'h1; j++)
         @(negedge sys_clk);
      if (j == 200)
         stall();
      busInit = 1'h1;
      repeat (6) @(negedge sys_clk);
      check(busBusyOe_n & busAddrOe_n & busDataOe_n, 1'h1);
      check(master_sync, 1'h0);
      busInit = 1'h0;
      slowSlave = 1'h0;
      repeat (4) @(negedge sys_clk);
      cmd = '{CMD_READ, 3'h1, 18'h00004, 16'h0000, 2'h1, 16'habcb, 1'h0};
      run(cmd, 2000, 1'h1);
      pop(cmd.exp);
      summarize();
   end
endmodule : tb_abt_bus_master
